// >>> logic/bus_sizer_regs.svh
`ifndef BUS_SIZER_REGS_SVH
`define BUS_SIZER_REGS_SVH

// processor-side state numbers, two half-clock states per bus clock
`define DS_RECOG        6'h02
`define DS_RELEASE      6'h04
`define DS_ACK          6'h06
`define DS_ACK_HOLD     6'h08
`define DS_STEP         6'h02
`define DS_LAST         6'h3E

// peripheral-side state numbers
`define PS_FIRST        6'h00
`define PS_STEP         6'h02
`define PS_LAST         6'h3E

// select logic: last edge count since select assertion on which an abort is still clean
`define SEL_ABORT_LAST  3'h1
// select logic: edge count since select assertion at which the processor may let go
`define SEL_RELEASE     3'h2
`define SEL_CNT_LAST    3'h7

// reset values
`define BUS_IDLE_N      1'b1
`define DATA_RESET      32'h0000_0000

`endif

// >>> logic/bus_sizer_pkg.sv
package bus_sizer_pkg;

	typedef enum logic [1:0] {
		PORT_WAIT,
		PORT_8,
		PORT_16,
		PORT_32
	} port_size_e;

	typedef logic [1:0] lane_t;

	// port-size acknowledge pair, both active low
	function automatic port_size_e decode_port_ack(input logic hi_n, input logic lo_n);
		port_size_e res;
		res = PORT_WAIT;
		unique case ({hi_n, lo_n})
			2'b00: res = PORT_32;
			2'b01: res = PORT_16;
			2'b10: res = PORT_8;
			2'b11: res = PORT_WAIT;
		endcase
		return res;
	endfunction

	// transfer size: equal bits mean long word, high-low a half word, low-high a byte
	function automatic lane_t first_byte(input logic sz_hi, input logic sz_lo, input lane_t addr);
		lane_t res;
		res = 2'h0;
		if (sz_hi != sz_lo) begin
			res = sz_hi ? {addr[1], 1'b0} : addr;
		end
		return res;
	endfunction

	function automatic lane_t last_byte(input logic sz_hi, input logic sz_lo, input lane_t addr);
		lane_t res;
		res = 2'h3;
		if (sz_hi != sz_lo) begin
			res = sz_hi ? {addr[1], 1'b1} : addr;
		end
		return res;
	endfunction

endpackage

// >>> logic/bus_sizer_if.sv
`timescale 1ns/100ps
interface bus_sizer_if (
	input wire logic clk
);
	logic        sel_n;
	logic        cycle_begin_n;
	logic        burst_inhibit_n;
	logic        addr_bit1;
	logic        addr_bit0;
	logic        xfer_size_hi;
	logic        xfer_size_lo;
	logic        read_not_write;
	logic [31:0] cpu_d;
	logic        cpu_d_oe_n;
	logic [31:0] dev_d;
	logic        dev_d_hi_oe_n;
	logic        dev_d_lo_oe_n;
	logic        access_ack_n;
	logic [31:0] d_bus;

	// shared processor data bus; undriven lanes read high
	always_comb begin
		d_bus = 32'hFFFF_FFFF;
		if (!cpu_d_oe_n) begin
			d_bus = cpu_d;
		end else begin
			if (!dev_d_hi_oe_n) begin
				d_bus[31:16] = dev_d[31:16];
			end
			if (!dev_d_lo_oe_n) begin
				d_bus[15:0] = dev_d[15:0];
			end
		end
	end

	modport dev (
		input  sel_n, addr_bit1, addr_bit0, xfer_size_hi, xfer_size_lo, read_not_write, d_bus,
		output dev_d, dev_d_hi_oe_n, dev_d_lo_oe_n, access_ack_n
	);

	modport cpu (
		input  access_ack_n, d_bus,
		output sel_n, cycle_begin_n, burst_inhibit_n, addr_bit1, addr_bit0, xfer_size_hi,
		       xfer_size_lo, read_not_write, cpu_d, cpu_d_oe_n
	);
endinterface

// >>> logic/sizer_cpu_end.sv
`timescale 1ns/100ps
`include "bus_sizer_regs.svh"
module sizer_cpu_end (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// bus toward the sizer
	bus_sizer_if.cpu         mpu,
	// requester side
	input  wire logic        req_i,
	input  wire logic        read_i,
	input  wire logic [1:0]  addr_i,
	input  wire logic [1:0]  size_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        early_release_i,
	input  wire logic        abort_i,
	output logic             busy_o,
	output logic             done_o,
	output logic             aborted_o,
	output logic [31:0]      rdata_o
);
	import bus_sizer_pkg::*;

	typedef enum {H_IDLE, H_BEGIN, H_SEL, H_GAP} host_state_e;

	host_state_e state_reg, state_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        sel_n_reg, sel_n_next;
	logic        begin_n_reg, begin_n_next;
	logic        rd_reg, rd_next;
	logic [1:0]  addr_reg, addr_next;
	logic [1:0]  size_reg, size_next;
	logic [31:0] wd_reg, wd_next;
	logic        doe_n_reg, doe_n_next;
	logic        early_reg, early_next;
	logic        done_reg, done_next;
	logic        abt_reg, abt_next;
	logic [31:0] rd_data_reg, rd_data_next;
	logic        busy_reg, busy_next;

	always_comb begin
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		sel_n_next   = sel_n_reg;
		begin_n_next = `BUS_IDLE_N;
		rd_next      = rd_reg;
		addr_next    = addr_reg;
		size_next    = size_reg;
		wd_next      = wd_reg;
		doe_n_next   = doe_n_reg;
		early_next   = early_reg;
		done_next    = 1'b0;
		abt_next     = 1'b0;
		rd_data_next = rd_data_reg;
		unique case (state_reg)
			H_IDLE: begin
				if (req_i) begin
					// control and write data stay put from the start pulse onward
					rd_next      = read_i;
					addr_next    = addr_i;
					size_next    = size_i;
					wd_next      = wdata_i;
					early_next   = early_release_i;
					doe_n_next   = read_i;
					begin_n_next = 1'b0;
					state_next   = H_BEGIN;
				end
			end
			H_BEGIN: begin
				// select one edge after the start pulse keeps the idle gap
				sel_n_next = 1'b0;
				cnt_next   = 3'h0;
				state_next = H_SEL;
			end
			H_SEL: begin
				if (cnt_reg != `SEL_CNT_LAST) begin
					cnt_next = cnt_reg + 3'h1;
				end
				if (abort_i && cnt_reg <= `SEL_ABORT_LAST) begin
					// late enough aborts are refused so no acknowledge can slip out
					sel_n_next = 1'b1;
					doe_n_next = 1'b1;
					abt_next   = 1'b1;
					state_next = H_GAP;
				end else if (early_reg && cnt_reg == `SEL_RELEASE) begin
					// processor moves on; acknowledge is not forwarded
					doe_n_next = 1'b1;
					done_next  = 1'b1;
				end
				if (!mpu.access_ack_n && !abt_next) begin
					// acknowledge seen: select negated on this same edge
					if (rd_reg) begin
						rd_data_next = mpu.d_bus;
					end
					done_next  = !early_reg && cnt_reg > `SEL_RELEASE ? 1'b1 : done_next;
					sel_n_next = 1'b1;
					doe_n_next = 1'b1;
					state_next = H_GAP;
				end
			end
			H_GAP: begin
				// select stays high across this edge
				state_next = H_IDLE;
			end
		endcase
		busy_next = state_next != H_IDLE;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg   <= H_IDLE;
			cnt_reg     <= 3'h0;
			sel_n_reg   <= `BUS_IDLE_N;
			begin_n_reg <= `BUS_IDLE_N;
			rd_reg      <= 1'b1;
			addr_reg    <= 2'h0;
			size_reg    <= 2'h0;
			wd_reg      <= `DATA_RESET;
			doe_n_reg   <= `BUS_IDLE_N;
			early_reg   <= 1'b0;
			done_reg    <= 1'b0;
			abt_reg     <= 1'b0;
			rd_data_reg <= `DATA_RESET;
			busy_reg    <= 1'b0;
		end else begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			sel_n_reg   <= sel_n_next;
			begin_n_reg <= begin_n_next;
			rd_reg      <= rd_next;
			addr_reg    <= addr_next;
			size_reg    <= size_next;
			wd_reg      <= wd_next;
			doe_n_reg   <= doe_n_next;
			early_reg   <= early_next;
			done_reg    <= done_next;
			abt_reg     <= abt_next;
			rd_data_reg <= rd_data_next;
			busy_reg    <= busy_next;
		end
	end

	// controls are stable from the start pulse until well past release
	assign mpu.sel_n           = sel_n_reg;
	assign mpu.cycle_begin_n   = begin_n_reg;
	assign mpu.addr_bit1       = addr_reg[1];
	assign mpu.addr_bit0       = addr_reg[0];
	assign mpu.xfer_size_hi    = size_reg[1];
	assign mpu.xfer_size_lo    = size_reg[0];
	assign mpu.read_not_write  = rd_reg;
	assign mpu.cpu_d           = wd_reg;
	assign mpu.cpu_d_oe_n      = doe_n_reg;
	// acknowledge doubles as burst inhibit
	assign mpu.burst_inhibit_n = mpu.access_ack_n;

	assign busy_o    = busy_reg;
	assign done_o    = done_reg;
	assign aborted_o = abt_reg;
	assign rdata_o   = rd_data_reg;
endmodule

// >>> logic/sizer_dev_end.sv
`timescale 1ns/100ps
`include "bus_sizer_regs.svh"
// Summary of operation
// - access states count half clocks from zero
// - processor holds controls stable until fourth state
// - late select may be recognized one edge later
// - select stays asserted until access ends
// - write data captured on recognizing edge, held
// - early select negation abandons access, data dropped
// - abort needs select negated before sixth state
// - bus changes after fourth state are ignored
// - select high one rising edge between accesses
// - early release: acknowledge not forwarded to processor
// - last transfer ends, acknowledge in sixth state
// - acknowledge held to eighth state, synchronous negation
// - later select negation drops acknowledge asynchronously
// - select held to sixth state for normal access
// - read data driven through eighth, released on negation
// - idle bus: data released, acknowledge negated
// - select asserted edge after start pulse or later
// - on 32-bit ports only upper 16 lanes cross peripheral side
// - peripherals wired by byte lane, top first
// - no bursts; acknowledge may inhibit bursts
// - peripheral side has its own state count
// - port acknowledge pair encodes port size or wait
// - equal size bits long word, high-low word
module sizer_dev_end #(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// processor bus
	bus_sizer_if.dev         mpu,
	// peripheral bus
	output logic [1:0]       periph_addr_o,
	output logic             periph_strobe_n_o,
	output logic             periph_write_n_o,
	output logic [15:0]      periph_d_o,
	output logic             periph_d_oe_n_o,
	input  wire logic [15:0] periph_d_i,
	input  wire logic        port_ack_hi_n_i,
	input  wire logic        port_ack_lo_n_i,
	// status
	output logic [5:0]       mpu_state_o,
	output logic [5:0]       periph_state_o
);
	import bus_sizer_pkg::*;

	typedef enum {D_IDLE, D_XFER, D_ACK, D_HOLD} dev_state_e;

	dev_state_e        state_reg, state_next;
	logic [5:0]        ds_reg, ds_next;
	logic [5:0]        ps_reg, ps_next;
	logic              seen_idle_reg, seen_idle_next;
	logic              rd_reg, rd_next;
	logic [DATA_W-1:0] wbuf_reg, wbuf_next;
	logic [DATA_W-1:0] rbuf_reg, rbuf_next;
	lane_t             cur_reg, cur_next;
	lane_t             last_reg, last_next;
	port_size_e        port_reg, port_next;
	logic              strobe_n_reg, strobe_n_next;
	logic              ack_n_reg, ack_n_next;
	logic              hold_reg, hold_next;
	logic              dhi_n_reg, dhi_n_next;
	logic              dlo_n_reg, dlo_n_next;
	logic              pdoe_n_reg, pdoe_n_next;
	logic              wr_n_reg, wr_n_next;
	logic [15:0]       pdata_reg, pdata_next;
	port_size_e        got;
	logic [2:0]        after;

	function automatic logic [7:0] pick(input logic [DATA_W-1:0] w, input lane_t k);
		return w[(31 - 8 * k) -: 8];
	endfunction

	function automatic logic [5:0] bump(input logic [5:0] s, input logic [5:0] step, input logic [5:0] top);
		return (s >= top) ? top : s + step;
	endfunction

	always_comb begin
		state_next     = state_reg;
		ds_next        = ds_reg;
		ps_next        = ps_reg;
		seen_idle_next = seen_idle_reg;
		rd_next        = rd_reg;
		wbuf_next      = wbuf_reg;
		rbuf_next      = rbuf_reg;
		cur_next       = cur_reg;
		last_next      = last_reg;
		port_next      = port_reg;
		strobe_n_next  = strobe_n_reg;
		ack_n_next     = ack_n_reg;
		hold_next      = hold_reg;
		dhi_n_next     = dhi_n_reg;
		dlo_n_next     = dlo_n_reg;
		pdoe_n_next    = pdoe_n_reg;
		// port acknowledge only counts while a strobe is out
		got            = decode_port_ack(port_ack_hi_n_i, port_ack_lo_n_i);
		after          = 3'h0;
		unique case (port_reg)
			PORT_8:    after = {1'b0, cur_reg} + 3'h1;
			PORT_16:   after = {1'b0, cur_reg[1], 1'b0} + 3'h2;
			PORT_32:   after = 3'h4;
			PORT_WAIT: after = 3'h4;
		endcase
		if (mpu.sel_n) begin
			seen_idle_next = 1'b1;
		end
		unique case (state_reg)
			D_IDLE: begin
				// a select that misses setup is simply taken one edge later
				if (!mpu.sel_n && seen_idle_reg) begin
					// controls and all write data latched on the recognizing edge
					seen_idle_next = 1'b0;
					rd_next        = mpu.read_not_write;
					wbuf_next      = mpu.d_bus;
					rbuf_next      = `DATA_RESET;
					cur_next       = first_byte(mpu.xfer_size_hi, mpu.xfer_size_lo,
						{mpu.addr_bit1, mpu.addr_bit0});
					last_next      = last_byte(mpu.xfer_size_hi, mpu.xfer_size_lo,
						{mpu.addr_bit1, mpu.addr_bit0});
					port_next      = PORT_WAIT;
					ds_next        = `DS_RECOG;
					ps_next        = `PS_FIRST;
					pdoe_n_next    = mpu.read_not_write;
					state_next     = D_XFER;
				end
			end
			D_XFER: begin
				// from here on only latched copies steer the transfer
				ds_next = bump(ds_reg, `DS_STEP, `DS_LAST);
				ps_next = bump(ps_reg, `PS_STEP, `PS_LAST);
				if (mpu.sel_n) begin
					// abandoned: nothing moved so far is kept
					strobe_n_next = 1'b1;
					pdoe_n_next   = 1'b1;
					rbuf_next     = `DATA_RESET;
					state_next    = D_IDLE;
				end else if (strobe_n_reg) begin
					strobe_n_next = 1'b0;
				end else if (got != PORT_WAIT) begin
					strobe_n_next = 1'b1;
					// size seen on the first transfer holds for the rest
					port_next     = (port_reg == PORT_WAIT) ? got : port_reg;
					unique case (port_next)
						PORT_8: begin
							rbuf_next[(31 - 8 * cur_reg) -: 8] = periph_d_i[15:8];
							after = {1'b0, cur_reg} + 3'h1;
						end
						PORT_16: begin
							rbuf_next[(31 - 16 * cur_reg[1]) -: 16] = periph_d_i;
							after = {1'b0, cur_reg[1], 1'b0} + 3'h2;
						end
						PORT_32: begin
							// the low half goes through outside transceivers
							rbuf_next[31:16] = periph_d_i;
							after = 3'h4;
						end
						PORT_WAIT: after = 3'h4;
					endcase
					if (after > {1'b0, last_reg}) begin
						// last transfer done; acknowledge and read data go out
						ack_n_next  = 1'b0;
						dhi_n_next  = !rd_reg;
						dlo_n_next  = !rd_reg || port_next == PORT_32;
						pdoe_n_next = 1'b1;
						ds_next     = `DS_ACK;
						state_next  = D_ACK;
					end else begin
						cur_next = after[1:0];
					end
				end
			end
			D_ACK: begin
				// acknowledge and read data stand at least through the eighth state
				ds_next = `DS_ACK_HOLD;
				if (mpu.sel_n) begin
					ack_n_next = 1'b1;
					dhi_n_next = 1'b1;
					dlo_n_next = 1'b1;
					state_next = D_IDLE;
				end else begin
					hold_next  = 1'b1;
					state_next = D_HOLD;
				end
			end
			D_HOLD: begin
				ds_next = bump(ds_reg, `DS_STEP, `DS_LAST);
				if (mpu.sel_n) begin
					ack_n_next = 1'b1;
					hold_next  = 1'b0;
					dhi_n_next = 1'b1;
					dlo_n_next = 1'b1;
					state_next = D_IDLE;
				end
			end
		endcase
		// registered so the peripheral pins come straight from flops
		wr_n_next      = strobe_n_next | rd_next;
		pdata_next     = {pick(wbuf_next, cur_next), pick(wbuf_next, cur_next | 2'h1)};
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg     <= D_IDLE;
			ds_reg        <= 6'h00;
			ps_reg        <= `PS_FIRST;
			seen_idle_reg <= 1'b0;
			rd_reg        <= 1'b1;
			wbuf_reg      <= `DATA_RESET;
			rbuf_reg      <= `DATA_RESET;
			cur_reg       <= 2'h0;
			last_reg      <= 2'h0;
			port_reg      <= PORT_WAIT;
			strobe_n_reg  <= `BUS_IDLE_N;
			ack_n_reg     <= `BUS_IDLE_N;
			hold_reg      <= 1'b0;
			dhi_n_reg     <= `BUS_IDLE_N;
			dlo_n_reg     <= `BUS_IDLE_N;
			pdoe_n_reg    <= `BUS_IDLE_N;
			wr_n_reg      <= `BUS_IDLE_N;
			pdata_reg     <= 16'h0000;
		end else begin
			state_reg     <= state_next;
			ds_reg        <= ds_next;
			ps_reg        <= ps_next;
			seen_idle_reg <= seen_idle_next;
			rd_reg        <= rd_next;
			wbuf_reg      <= wbuf_next;
			rbuf_reg      <= rbuf_next;
			cur_reg       <= cur_next;
			last_reg      <= last_next;
			port_reg      <= port_next;
			strobe_n_reg  <= strobe_n_next;
			ack_n_reg     <= ack_n_next;
			hold_reg      <= hold_next;
			dhi_n_reg     <= dhi_n_next;
			dlo_n_reg     <= dlo_n_next;
			pdoe_n_reg    <= pdoe_n_next;
			wr_n_reg      <= wr_n_next;
			pdata_reg     <= pdata_next;
		end
	end

	// past the eighth state a negated select releases at once, no clock edge
	// the only non-registered outputs; the bus demands the gate delay path
	assign mpu.access_ack_n  = ack_n_reg | (hold_reg & mpu.sel_n);
	assign mpu.dev_d_hi_oe_n = dhi_n_reg | (hold_reg & mpu.sel_n);
	assign mpu.dev_d_lo_oe_n = dlo_n_reg | (hold_reg & mpu.sel_n);
	assign mpu.dev_d         = rbuf_reg;

	// byte k on the top lane, the odd byte of its word on the second lane
	assign periph_d_o        = pdata_reg;
	assign periph_addr_o     = cur_reg;
	assign periph_strobe_n_o = strobe_n_reg;
	assign periph_write_n_o  = wr_n_reg;
	assign periph_d_oe_n_o   = pdoe_n_reg;
	assign mpu_state_o       = ds_reg;
	assign periph_state_o    = ps_reg;
endmodule

// >>> tb/bus_sizer_monitor.sv
`timescale 1ns/100ps
module bus_sizer_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic resetn_i,
	// processor bus
	input wire logic sel_n,
	input wire logic cycle_begin_n,
	input wire logic burst_inhibit_n,
	input wire logic access_ack_n,
	input wire logic dev_d_hi_oe_n,
	input wire logic dev_d_lo_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn_i);

	sequence s_begin_sel;
		!cycle_begin_n ##1 (cycle_begin_n && !sel_n);
	endsequence
	// ack seen low at one edge, then select seen rising at the next
	sequence s_ack_release;
		!access_ack_n ##1 $rose(sel_n);
	endsequence

	property p_start;
		$fell(cycle_begin_n) |-> s_begin_sel;
	endproperty
	property p_gap;
		$rose(sel_n) |=> sel_n;
	endproperty
	// ack may only let go once select is negated
	property p_ack_stand;
		$rose(access_ack_n) |-> sel_n;
	endproperty
	// ack needs select seen low on the recognizing edge and three more
	property p_ack_late;
		$fell(access_ack_n) |-> !sel_n && !$past(sel_n) && !$past(sel_n, 2) && !$past(sel_n, 3);
	endproperty
	property p_idle;
		sel_n && $past(sel_n) |-> access_ack_n && dev_d_hi_oe_n && dev_d_lo_oe_n;
	endproperty
	// past the hold edge the ack drop follows select without waiting for a clock
	property p_async;
		s_ack_release |-> access_ack_n;
	endproperty
	property p_burst;
		burst_inhibit_n == access_ack_n;
	endproperty
	property p_read_hold;
		$rose(dev_d_hi_oe_n) |-> sel_n;
	endproperty
	property p_oe_ack;
		!dev_d_hi_oe_n || !dev_d_lo_oe_n |-> !access_ack_n;
	endproperty

	a_start: assert property (p_start) else $error("select did not follow start pulse");
	a_gap: assert property (p_gap) else $error("select gap too short");
	a_ack_stand: assert property (p_ack_stand) else $error("ack dropped too early");
	a_ack_late: assert property (p_ack_late) else $error("ack too early after select");
	a_idle: assert property (p_idle) else $error("bus busy while idle");
	a_async: assert property (p_async) else $error("ack held after select negation");
	a_burst: assert property (p_burst) else $error("burst inhibit differs from ack");
	a_read_hold: assert property (p_read_hold) else $error("read data not held");
	a_oe_ack: assert property (p_oe_ack) else $error("data driven without ack");
	c_async: cover property (p_async);
endmodule

// >>> tb/dynamic_bus_sizer_mpu_side_test.sv
`timescale 1ns/100ps
`include "bus_sizer_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module dynamic_bus_sizer_mpu_side_test;
	import bus_sizer_pkg::*;
	logic        clk_i, resetn_i, req_i, read_i, early_release_i, abort_i;
	logic [1:0]  addr_i, size_i, periph_addr_o;
	logic [31:0] wdata_i, rdata_o, rdata;
	logic        busy_o, done_o, aborted_o, fin;
	logic        periph_strobe_n_o, periph_write_n_o, port_ack_hi_n_i, port_ack_lo_n_i;
	logic [15:0] periph_d_o, periph_d_i;
	logic [7:0]  mem [4];
	logic [1:0]  pcode;
	logic [5:0]  mpu_state_o, dstate;
	int          waits, wcnt, cycles, err_total, n_compared;
	logic [1:0]  codes [3] = '{2'b00, 2'b01, 2'b10};
	logic [31:0] exp_rd [3] = '{32'h1122_FFFF, 32'h1122_3344, 32'h1122_3344};

	bus_sizer_if i_bus_sizer_if (.clk(clk_i));
	sizer_cpu_end i_sizer_cpu_end (.clk_i(clk_i), .resetn_i(resetn_i), .mpu(i_bus_sizer_if), .req_i(req_i),
		.read_i(read_i), .addr_i(addr_i), .size_i(size_i), .wdata_i(wdata_i), .early_release_i(early_release_i),
		.abort_i(abort_i), .busy_o(busy_o), .done_o(done_o), .aborted_o(aborted_o), .rdata_o(rdata_o));
	sizer_dev_end i_sizer_dev_end (.clk_i(clk_i), .resetn_i(resetn_i), .mpu(i_bus_sizer_if),
		.periph_addr_o(periph_addr_o), .periph_strobe_n_o(periph_strobe_n_o), .periph_write_n_o(periph_write_n_o),
		.periph_d_o(periph_d_o), .periph_d_oe_n_o(), .periph_d_i(periph_d_i), .port_ack_hi_n_i(port_ack_hi_n_i),
		.port_ack_lo_n_i(port_ack_lo_n_i), .mpu_state_o(mpu_state_o), .periph_state_o());
	bus_sizer_monitor i_bus_sizer_monitor (.clk(clk_i), .resetn_i(resetn_i), .sel_n(i_bus_sizer_if.sel_n),
		.cycle_begin_n(i_bus_sizer_if.cycle_begin_n), .burst_inhibit_n(i_bus_sizer_if.burst_inhibit_n),
		.access_ack_n(i_bus_sizer_if.access_ack_n), .dev_d_hi_oe_n(i_bus_sizer_if.dev_d_hi_oe_n),
		.dev_d_lo_oe_n(i_bus_sizer_if.dev_d_lo_oe_n));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// peripheral: answers after waits, data lines scrambled while not strobed
	always @(negedge clk_i) begin
		if (!periph_strobe_n_o && wcnt < waits) begin
			wcnt <= wcnt + 1;
		end else if (!periph_strobe_n_o) begin
			{port_ack_hi_n_i, port_ack_lo_n_i} <= pcode;
			if (!periph_write_n_o) begin
				mem[periph_addr_o] <= periph_d_o[15:8];
				if (pcode != 2'b10) begin
					mem[periph_addr_o | 2'h1] <= periph_d_o[7:0];
				end
			end
		end else begin
			{port_ack_hi_n_i, port_ack_lo_n_i} <= 2'b11;
			wcnt <= 0;
		end
		periph_d_i <= periph_strobe_n_o ? ~periph_d_i : {mem[periph_addr_o], mem[periph_addr_o | 2'h1]};
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (err_total == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one whole access through the requester; fin tells done from abort
	task automatic access(input logic rd, input logic [1:0] a, input logic [1:0] sz, input logic [31:0] wd,
		input logic er, input logic ab);
		int k;
		read_i = rd;
		addr_i = a;
		size_i = sz;
		wdata_i = wd;
		early_release_i = er;
		abort_i = ab;
		req_i = 1'b1;
		for (k = 0; k < 60 && i_bus_sizer_if.cycle_begin_n !== 1'b0; k++) @(negedge clk_i);
		req_i = 1'b0;
		for (k = 0; k < 200 && done_o !== 1'b1 && aborted_o !== 1'b1; k++) @(negedge clk_i);
		fin = done_o;
		dstate = mpu_state_o;
		rdata = rdata_o;
		abort_i = 1'b0;
		@(negedge clk_i);
	endtask

	initial begin
		resetn_i = 1'b0;
		req_i = 1'b0;
		read_i = 1'b0;
		addr_i = 2'h0;
		size_i = 2'h0;
		wdata_i = 32'h0;
		early_release_i = 1'b0;
		abort_i = 1'b0;
		{port_ack_hi_n_i, port_ack_lo_n_i} = 2'b11;
		periph_d_i = 16'h0;
		pcode = 2'b00;
		waits = 0;
		wcnt = 0;
		cycles = 0;
		err_total = 0;
		n_compared = 0;
		mem = '{8'h11, 8'h22, 8'h33, 8'h44};
		repeat (5) @(negedge clk_i);
		resetn_i = 1'b1;
		`CHK("ack after reset", 1'b1, i_bus_sizer_if.access_ack_n)
		`CHK("bus after reset", 32'hFFFF_FFFF, i_bus_sizer_if.d_bus)
		// long reads from every port width, both long size codes
		for (int p = 0; p < 3; p++) begin
			pcode = codes[p];
			waits = p;
			access(1'b1, 2'h0, p[0] ? 2'b11 : 2'b00, 32'h0, 1'b0, 1'b0);
			`CHK("long read done", 1'b1, fin)
			`CHK("hold state", `DS_ACK_HOLD, dstate)
			`CHK("long read data", exp_rd[p], rdata)
			`CHK("idle after read", 1'b0, busy_o)
		end
		pcode = 2'b10;
		waits = 0;
		access(1'b0, 2'h0, 2'b00, 32'hA1B2_C3D4, 1'b0, 1'b0);
		`CHK("long write", 32'hA1B2_C3D4, {mem[0], mem[1], mem[2], mem[3]})
		pcode = 2'b01;
		access(1'b0, 2'h2, 2'b10, 32'h0000_5566, 1'b0, 1'b0);
		`CHK("word write", 32'hA1B2_5566, {mem[0], mem[1], mem[2], mem[3]})
		pcode = 2'b10;
		access(1'b0, 2'h1, 2'b01, 32'h0077_0000, 1'b0, 1'b0);
		`CHK("byte write", 32'hA177_5566, {mem[0], mem[1], mem[2], mem[3]})
		pcode = 2'b01;
		access(1'b1, 2'h2, 2'b10, 32'h0, 1'b0, 1'b0);
		`CHK("word read", 16'h5566, rdata[15:0])
		// abort while a slow byte port holds off
		pcode = 2'b10;
		waits = 6;
		access(1'b0, 2'h0, 2'b00, 32'h0, 1'b0, 1'b1);
		`CHK("abort done", 1'b0, fin)
		`CHK("abort write", 32'hA177_5566, {mem[0], mem[1], mem[2], mem[3]})
		// early release, then a read right behind it
		waits = 3;
		access(1'b0, 2'h0, 2'b00, 32'h9988_7766, 1'b1, 1'b0);
		`CHK("early done", 1'b1, fin)
		access(1'b1, 2'h0, 2'b00, 32'h0, 1'b0, 1'b0);
		`CHK("after early", 32'h9988_7766, rdata)
		wrap_up();
	end
endmodule
